// ==== logic/spcr_serial_port.sv ====
// Serial host port, master clock chain, data-ready pulse and sinc decimator
`default_nettype none

module spcr_serial_port (
  input  wire logic                    ref_clk_i,          // System clock, 20 MHz
  input  wire logic                    reset_n_i,          // Asynchronous reset
  input  wire logic                    device_reset_n_i,   // Reset pin level
  input  wire logic                    watchdog_reset_i,   // Watchdog timer reset pulse
  input  wire logic                    interface_sel_i,    // Low SPI, high two-wire
  input  wire spcr_pkg::spcr_clk_cfg_s clk_cfg_i,          // Clock chain configuration
  input  wire logic [1:0]              word_width_sel_i,   // Data word width code
  input  wire logic                    crystal_clock_i,    // Oscillator clock level
  input  wire logic                    direct_clock_in_i,  // Direct clock input level
  input  wire logic                    modulator_bit_i,    // Modulator output bit
  input  wire logic                    chip_select_n_i,    // SPI chip select
  input  wire logic                    serial_clock_i,     // Serial clock pin level
  input  wire logic                    serial_in_i,        // Serial data input pin
  output logic                         serial_out_o,       // Serial data output value
  output logic                         serial_out_oe_o,    // High while the pin is driven
  output logic                         result_ready_n_o,   // Data-ready pulse, active low
  output logic [spcr_pkg::RESULT_W-1:0] result_o,          // Latest conversion result
  output logic [31:0]                  write_data_o,       // Last written data word
  output logic                         write_valid_o,      // One-cycle pulse per word
  output logic                         two_wire_mode_o,    // Latched interface mode
  output logic                         spi_mode11_o,       // Serial clock idled high
  output logic                         oversample_pin_hi_o // Latched upper oversample bit
);
  import spcr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                sck_reg;          // Serial clock, previous cycle
  logic                cs_n_reg;         // Chip select, previous cycle
  logic                xtal_reg;         // Oscillator clock, previous cycle
  logic                direct_clock_in_reg;         // Direct clock, previous cycle
  logic                sck_rise;         // Serial clock rising edge
  logic                sck_fall;         // Serial clock falling edge
  logic                cs_fall;          // Chip select falling edge
  logic                mode_pend_reg;    // Mode capture still owed after reset
  logic                mclk_tick;        // One master clock period elapsed
  logic [2:0]          pre_cnt_reg;      // Prescale divider count
  logic [2:0]          pre_last;         // Last prescale count
  logic                analog_tick;      // One analog clock period elapsed
  logic [1:0]          quarter_cnt_reg;  // Divide-by-four count
  logic                sample_tick;      // One sample clock period elapsed
  logic [2:0]          osr_eff;          // Oversample code actually in use
  logic [11:0]         osr_cnt_reg;      // Samples into the current result
  logic [11:0]         osr_last;         // Last sample of a result
  logic                result_done;      // Sample tick that closes a window
  logic [ACC_W-1:0]    acc_reg;          // Ones counted over the window
  logic                ready_evt_reg;    // One-cycle pulse per new result
  logic [4:0]          ready_cnt_reg;    // Master ticks left in the pulse
  logic [4:0]          ready_width;      // Half sample period in master ticks
  spcr_spi_state_e     state_reg;        // SPI transfer state
  logic [5:0]          bit_cnt_reg;      // Bits in the current byte or word
  logic [5:0]          word_bits;        // Data word length in bits
  logic [7:0]          cmd_reg;          // Command shift register
  logic [31:0]         shift_reg;        // Data shift register, both ways
  logic                link_open;        // Transfer allowed to proceed

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  // Serial and master clocks are sampled as plain levels on the system
  // clock, so their phase relation never matters to the logic.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_reg  <= 1'b0;
      cs_n_reg <= 1'b1;
      xtal_reg <= 1'b0;
      direct_clock_in_reg <= 1'b0;
    end else begin
      sck_reg  <= serial_clock_i;
      cs_n_reg <= chip_select_n_i;
      xtal_reg <= crystal_clock_i;
      direct_clock_in_reg <= direct_clock_in_i;
    end
  end

  assign sck_rise  = serial_clock_i & ~sck_reg;
  assign sck_fall  = ~serial_clock_i & sck_reg;
  assign cs_fall   = ~chip_select_n_i & cs_n_reg;
  assign link_open = ~chip_select_n_i & device_reset_n_i;

  // ----------------------------------------------------------------
  // Interface mode latch
  // ----------------------------------------------------------------
  // The select level is caught on the first edge after reset release,
  // never under the asynchronous reset itself, and again per watchdog.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_pend_reg       <= 1'b1;
      two_wire_mode_o     <= 1'b0;
      oversample_pin_hi_o <= 1'b0;
    end else begin
      mode_pend_reg <= 1'b0;
      if (mode_pend_reg || watchdog_reset_i) begin
        two_wire_mode_o <= interface_sel_i;
        // Pin caught on entry to two-wire mode and at each watchdog reset that selects two-wire
        if (interface_sel_i && (!two_wire_mode_o || watchdog_reset_i || mode_pend_reg)) begin
          oversample_pin_hi_o <= serial_in_i;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock source and prescaler
  // ----------------------------------------------------------------
  // Two-wire mode runs the whole chain from the serial clock, so a gap
  // in that clock stalls conversion as well as the link.
  assign mclk_tick = two_wire_mode_o ? sck_rise :
                     (clk_cfg_i.external_clock_sel ? (direct_clock_in_i & ~direct_clock_in_reg) :
                                                     (crystal_clock_i & ~xtal_reg));
  assign pre_last  = 3'((4'h1 << clk_cfg_i.prescale) - 4'h1);
  assign analog_tick = mclk_tick && (pre_cnt_reg >= pre_last);

  // Prescale divider; a count above a freshly lowered limit wraps at once
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_cnt_reg <= 3'h0;
    end else if (mclk_tick) begin
      if (pre_cnt_reg >= pre_last) begin
        pre_cnt_reg <= 3'h0;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample clock: analog clock divided by four
  // ----------------------------------------------------------------
  assign sample_tick = analog_tick && (quarter_cnt_reg == SAMPLE_DIV_LAST);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quarter_cnt_reg <= 2'h0;
    end else if (analog_tick) begin
      quarter_cnt_reg <= quarter_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Oversampling and sinc decimation
  // ----------------------------------------------------------------
  // Two-wire mode takes the upper ratio bit from the latched pin.
  always_comb begin
    osr_eff = clk_cfg_i.oversample_sel;
    if (two_wire_mode_o) begin
      osr_eff[OSR_PIN_POS] = oversample_pin_hi_o;
    end
  end

  // Ratio doubles per code step, 32 to 4096, with any prescale.
  assign osr_last = 12'((13'h1 << (OSR_BASE_LOG2 + {1'b0, osr_eff})) - 13'h1);
  assign result_done = sample_tick && (osr_cnt_reg >= osr_last);

  // A boxcar over exactly one output period: its response is zero at
  // every multiple of the data rate. Cheap, but only first order.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osr_cnt_reg   <= 12'h000;
      acc_reg       <= '0;
      result_o      <= '0;
      ready_evt_reg <= 1'b0;
    end else begin
      ready_evt_reg <= 1'b0;
      if (sample_tick) begin
        // Exactly one modulator bit taken per sample period.
        if (osr_cnt_reg >= osr_last) begin
          osr_cnt_reg   <= 12'h000;
          acc_reg       <= '0;
          result_o      <= RESULT_W'(acc_reg + ACC_W'(modulator_bit_i));
          ready_evt_reg <= 1'b1;
        end else begin
          osr_cnt_reg <= osr_cnt_reg + 12'h001;
          acc_reg     <= acc_reg + ACC_W'(modulator_bit_i);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data-ready pulse
  // ----------------------------------------------------------------
  assign ready_width = 5'(READY_HALF_BASE << clk_cfg_i.prescale);

  // Low for half a sample period counted in master ticks, so it follows
  // the master clock; nothing holds it once the count runs out.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_cnt_reg    <= 5'h00;
      result_ready_n_o <= 1'b1;
    end else if (two_wire_mode_o) begin
      ready_cnt_reg    <= 5'h00;  // Pin is an input here, never pulsed
      result_ready_n_o <= 1'b1;
    end else begin
      // Falls on the master tick that closes the window, so it is exactly half a period
      if (result_done) begin
        ready_cnt_reg    <= ready_width;
        result_ready_n_o <= 1'b0;
      end else if (mclk_tick && ready_cnt_reg != 5'h00) begin
        ready_cnt_reg    <= ready_cnt_reg - 5'h01;
        result_ready_n_o <= (ready_cnt_reg == 5'h01);
      end
    end
  end

  // ----------------------------------------------------------------
  // Word width decode
  // ----------------------------------------------------------------
  always_comb begin
    case (word_width_sel_i)
      WORD_16: word_bits = WORD_16_BITS;
      WORD_24: word_bits = WORD_24_BITS;
      WORD_32: word_bits = WORD_32_BITS;
      default: word_bits = WORD_24_BITS;  // Unused code falls back to 24
    endcase
  end

  // ----------------------------------------------------------------
  // Serial link: SPI transfers and two-wire frames
  // ----------------------------------------------------------------
  // One process owns the output pin so the two modes never fight over it.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg       <= ST_IDLE;
      bit_cnt_reg     <= 6'h00;
      cmd_reg         <= 8'h00;
      shift_reg       <= 32'h0000_0000;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
      write_data_o    <= 32'h0000_0000;
      write_valid_o   <= 1'b0;
      spi_mode11_o    <= 1'b0;
    end else begin
      write_valid_o <= 1'b0;
      if (two_wire_mode_o) begin
        // Only output in this mode, so it is driven all the time.
        state_reg       <= ST_IDLE;
        serial_out_oe_o <= 1'b1;
        if (ready_evt_reg) begin
          shift_reg   <= result_next_frame();
          bit_cnt_reg <= FRAME_BITS;
        end else if (sck_fall && bit_cnt_reg != 6'h00) begin
          serial_out_o <= shift_reg[31];
          shift_reg    <= {shift_reg[30:0], 1'b0};
          bit_cnt_reg  <= bit_cnt_reg - 6'h01;
        end
      end else if (!link_open) begin
        // Chip select high or reset pin low: pin released, transfer dropped
        state_reg       <= ST_IDLE;
        serial_out_oe_o <= 1'b0;
        bit_cnt_reg     <= 6'h00;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (cs_fall) begin
              state_reg    <= ST_CMD;
              spi_mode11_o <= serial_clock_i;
              bit_cnt_reg  <= 6'h00;
            end
          end
          ST_CMD: begin
            serial_out_oe_o <= 1'b0;
            if (sck_rise) begin
              cmd_reg <= {cmd_reg[6:0], serial_in_i};
              if (bit_cnt_reg == CMD_BITS - 6'h01) begin
                bit_cnt_reg <= 6'h00;
                if (serial_in_i == 1'b1 && CMD_READ_POS == 0) begin
                  state_reg <= ST_READ;
                  shift_reg <= load_word();
                end else begin
                  state_reg <= ST_WRITE;
                  shift_reg <= 32'h0000_0000;
                end
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
              end
            end
          end
          ST_WRITE: begin
            // Output stays released through the whole write.
            serial_out_oe_o <= 1'b0;
            if (sck_rise) begin
              if (bit_cnt_reg == word_bits - 6'h01) begin
                bit_cnt_reg   <= 6'h00;
                shift_reg     <= 32'h0000_0000;  // Next word starts clean, right-aligned
                write_data_o  <= {shift_reg[30:0], serial_in_i};
                write_valid_o <= 1'b1;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                shift_reg   <= {shift_reg[30:0], serial_in_i};
              end
            end
          end
          ST_READ: begin
            // Input pin not looked at here: reads are output only.
            if (sck_fall) begin
              serial_out_oe_o <= 1'b1;
              serial_out_o    <= shift_reg[31];
              if (bit_cnt_reg == word_bits - 6'h01) begin
                bit_cnt_reg <= 6'h00;
                shift_reg   <= load_word();  // Continuous read reloads the latest result
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                shift_reg   <= {shift_reg[30:0], 1'b0};
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Word loading helpers
  // ----------------------------------------------------------------
  // Read word, left-justified in the shift register; 16 bits keep the top
  function automatic logic [31:0] load_word();
    logic [31:0] word;
    word = {result_o, 8'h00};
    if (word_width_sel_i == WORD_16) begin
      word = {result_o[RESULT_W-1:8], 16'h0000};
    end
    return word;
  endfunction : load_word

  // Two-wire frame word, left-justified
  function automatic logic [31:0] result_next_frame();
    return {result_o, 8'h00};
  endfunction : result_next_frame

endmodule : spcr_serial_port

`default_nettype wire

// ==== logic/spcr_pkg.sv ====
// Shared constants, carrier types and state codes for the serial port and rate clocks
`default_nettype none

package spcr_pkg;

  // ----------------------------------------------------------------
  // Reset values of the clock configuration
  // ----------------------------------------------------------------
  localparam logic [1:0] PRESCALE_RESET   = 2'h0;  // Divide by one
  localparam logic [2:0] OVERSAMPLE_RESET = 3'h3;  // Ratio 256

  // ----------------------------------------------------------------
  // Divider and timing counts
  // ----------------------------------------------------------------
  localparam logic [1:0] SAMPLE_DIV_LAST  = 2'h3;  // Analog clock divided by four
  localparam logic [3:0] OSR_BASE_LOG2    = 4'h5;  // Code 000 selects a ratio of 32
  localparam logic [4:0] READY_HALF_BASE  = 5'h2;  // Half sample period, in master ticks
  localparam logic [5:0] CMD_BITS         = 6'h08; // Command byte length
  localparam logic [5:0] FRAME_BITS       = 6'h18; // Two-wire frame length

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int         CMD_READ_POS     = 0;     // Command bit that marks a read
  localparam int         OSR_PIN_POS      = 2;     // Oversample bit replaced by the pin
  localparam logic [1:0] WORD_16          = 2'h0;  // Data word width codes
  localparam logic [1:0] WORD_24          = 2'h1;
  localparam logic [1:0] WORD_32          = 2'h2;
  localparam logic [5:0] WORD_16_BITS     = 6'h10;
  localparam logic [5:0] WORD_24_BITS     = 6'h18;
  localparam logic [5:0] WORD_32_BITS     = 6'h20;
  localparam int         RESULT_W         = 24;    // Conversion result width
  localparam int         ACC_W            = 13;    // Ones count up to 4096

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       external_clock_sel;  // 1 selects the direct clock input
    logic [1:0] prescale;            // Analog clock prescale code
    logic [2:0] oversample_sel;      // Oversampling ratio code
  } spcr_clk_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // No transfer open
    ST_CMD   = 2'b01,  // Receiving the command byte
    ST_WRITE = 2'b10,  // Receiving write data words
    ST_READ  = 2'b11   // Sending read data words
  } spcr_spi_state_e;

endpackage : spcr_pkg

`default_nettype wire

// ==== tb/spcr_serial_port_asserts.sv ====
// Port timing checker for the serial port and rate clocks
`default_nettype none

module spcr_serial_port_asserts (
  input wire logic ref_clk_i,         // System clock
  input wire logic reset_n_i,         // Asynchronous reset
  input wire logic device_reset_n_i,  // Reset pin level
  input wire logic chip_select_n_i,   // SPI chip select
  input wire logic serial_clock_i,    // Serial clock pin
  input wire logic serial_out_o,      // Output value
  input wire logic serial_out_oe_o,   // Output enable
  input wire logic result_ready_n_o,  // Ready pulse
  input wire logic write_valid_o,     // Write word strobe
  input wire logic two_wire_mode_o,   // Latched mode
  input wire logic spi_mode11_o       // Latched clock idle level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties, all in the system clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_oe_cs_high:
    assert property ((!two_wire_mode_o && chip_select_n_i) [*4] |-> !serial_out_oe_o)
      else $error("output pin driven while chip select high");
  a_oe_pin_reset:
    assert property ((!two_wire_mode_o && !device_reset_n_i) [*4] |-> !serial_out_oe_o)
      else $error("output pin driven while reset pin low");
  a_read_no_write:
    assert property (serial_out_oe_o && !two_wire_mode_o |-> !write_valid_o)
      else $error("write word taken during a read");
  a_write_framed:
    assert property (write_valid_o |-> !$past(chip_select_n_i, 2))
      else $error("write word completed outside a transfer");
  // Output may only move after a fall, so it holds while the clock stays high
  a_out_hold:
    assert property ((serial_out_oe_o && serial_clock_i && !two_wire_mode_o) [*3]
                     |-> $stable(serial_out_o))
      else $error("output bit changed while serial clock high");
  a_mode_hi_seen:
    assert property ($fell(chip_select_n_i) && serial_clock_i && !two_wire_mode_o
                     |-> ##6 spi_mode11_o)
      else $error("clock idle high not latched");
  a_mode_lo_seen:
    assert property ($fell(chip_select_n_i) && !serial_clock_i && !two_wire_mode_o
                     |-> ##6 !spi_mode11_o)
      else $error("clock idle low not latched");
  a_tw_ready_off:
    assert property (two_wire_mode_o [*3] |-> result_ready_n_o)
      else $error("ready pulse in two-wire mode");
  a_tw_out_on:
    assert property (two_wire_mode_o [*3] |-> serial_out_oe_o)
      else $error("output pin released in two-wire mode");
  // One pulse per result period, so a rise is followed by a long high time
  a_ready_gap:
    assert property ($rose(result_ready_n_o) |-> result_ready_n_o [*8])
      else $error("ready pulse repeated too soon");
endmodule : spcr_serial_port_asserts

bind spcr_serial_port spcr_serial_port_asserts u_chk (.ref_clk_i, .reset_n_i,
  .device_reset_n_i, .chip_select_n_i, .serial_clock_i, .serial_out_o, .serial_out_oe_o,
  .result_ready_n_o, .write_valid_o, .two_wire_mode_o, .spi_mode11_o);

`default_nettype wire

// ==== tb/spcr_host_model.sv ====
// Host controller model acting as SPI master on the serial port
`default_nettype none

module spcr_host_model (
  input  wire logic clk_i,   // Bench clock
  input  wire logic oe_i,    // Device drives the output pin
  input  wire logic out_i,   // Device output value
  input  wire logic run_i,   // Free-running clock for two-wire
  output var  logic cs_n_o,  // Chip select
  output var  logic sck_o,   // Serial clock
  output var  logic sdi_o    // Data to the device
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Pin view and clocking
  // ----------------------------------------------------------------
  logic held;  // Last level the device drove
  logic pin;   // Output pin level as seen here
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    held = 1'b0;
  end
  // Released pin shows the inverse of its last level, so stale data never matches
  always @(posedge clk_i) if (oe_i) held <= out_i;
  assign pin = oe_i ? out_i : ~held;
  // Two-wire clock has no gaps; it also serves as master clock
  always @(posedge clk_i) if (run_i) sck_o <= ~sck_o;
  // One transfer, MSB first, four bench cycles per clock phase
  task automatic xfer(input logic m11, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    @(posedge clk_i);
    sck_o <= m11;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      sck_o <= 1'b0;
      sdi_o <= din[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      dout[i] = pin;
      repeat (4) @(posedge clk_i);
    end
    sck_o <= m11;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
  endtask : xfer
endmodule : spcr_host_model

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the serial port and rate clocks
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spcr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                clk, rst_n, dev_rst_n, wdog, if_sel, xtal, dclk_run, run, tw_sdi;
  logic [1:0]          dcnt, wsel;       // Direct clock divider, word width
  spcr_clk_cfg_s       cfg;              // Clock chain setting
  logic                cs_n, sck, sdi, sdo, sdo_oe, rdy_n, wv, tw, m11, osr_hi;
  logic [RESULT_W-1:0] result;
  logic [31:0]         wdata;
  logic [63:0]         rx, wd;
  int                  err_total, n_tests, n, ones;

  always #25 clk = ~clk;
  // Crystal ticks every 2 cycles, direct clock every 4 so the source shows
  always @(posedge clk) xtal <= ~xtal;
  always @(posedge clk) if (dclk_run) dcnt <= dcnt + 2'h1;

  spcr_serial_port dut (.ref_clk_i(clk), .reset_n_i(rst_n), .device_reset_n_i(dev_rst_n),
    .watchdog_reset_i(wdog), .interface_sel_i(if_sel), .clk_cfg_i(cfg),
    .word_width_sel_i(wsel), .crystal_clock_i(xtal), .direct_clock_in_i(dcnt[1]),
    .modulator_bit_i(1'b1), .chip_select_n_i(cs_n), .serial_clock_i(sck),
    .serial_in_i(run ? tw_sdi : sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
    .result_ready_n_o(rdy_n), .result_o(result), .write_data_o(wdata),
    .write_valid_o(wv), .two_wire_mode_o(tw), .spi_mode11_o(m11),
    .oversample_pin_hi_o(osr_hi));

  spcr_host_model host (.clk_i(clk), .oe_i(sdo_oe), .out_i(sdo), .run_i(run),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Cycles up to the next ready fall, stopping at lim
  task automatic next_fall(input int lim, output int k);
    logic last;
    last = rdy_n;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (last === 1'b1 && rdy_n === 1'b0) break;
      last = rdy_n;
    end while (k < lim);
  endtask : next_fall

  // Settle, then check pulse width, period and ones count; tc cycles per tick
  task automatic measure(input logic ext, input int pre, input int osr, input int tc);
    int w, k;
    w = 0;
    @(posedge clk);
    cfg <= '{ext, 2'(pre), 3'(osr)};
    next_fall(20000, k);
    next_fall(20000, k);
    while (rdy_n === 1'b0 && w < 200) begin
      @(negedge clk);
      w++;
    end
    next_fall(20000, k);
    chk(32'(w), 32'((2 << pre) * tc));
    chk(32'(w + k), 32'((128 << (osr + pre)) * tc));
    chk(32'(result), 32'(32 << osr));
  endtask : measure

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, rst_n, wdog, if_sel, xtal, dclk_run, run, tw_sdi} = '0;
    dev_rst_n = 1'b1;
    dcnt = 2'h0;
    wsel = WORD_16;
    cfg = '{1'b0, 2'h0, 3'h0};
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({tw, sdo_oe, rdy_n, wv}, 32'h2);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 1; p < 4; p++) measure(1'b0, p, 0, 2);
    for (int o = 0; o < 5; o++) measure(1'b0, 0, o, 2);
    // Direct input selected but stopped: no results at all
    @(posedge clk);
    cfg <= '{1'b1, 2'h0, 3'h0};
    next_fall(1000, n);
    chk(32'(n), 32'h3e8);
    dclk_run <= 1'b1;
    measure(1'b1, 0, 0, 4);
    // Writes in every word width, last one in clock mode 1,1
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      wsel <= 2'(k);
      wd = 64'hc3a55a3c & ((64'h1 << (16 + 8 * k)) - 64'h1);  // Word trimmed to its width
      host.xfer(k == 2, 24 + 8 * k, (64'h02 << (16 + 8 * k)) | wd, rx);
      chk(wdata, wd[31:0]);
      chk({31'h0, m11}, 32'(k == 2));
    end
    // Read with toggling input: released during the command, result word after
    @(posedge clk);
    wsel <= WORD_24;
    host.xfer(1'b0, 32, 64'h015a5aa5, rx);
    chk(rx[31:0], 32'hff000020);
    chk(wdata, 32'hc3a55a3c);
    // Reset pin low blocks a write
    @(posedge clk);
    dev_rst_n <= 1'b0;
    host.xfer(1'b0, 32, 64'h02112233, rx);
    chk(wdata, 32'hc3a55a3c);
    dev_rst_n <= 1'b1;
    // Two-wire entry through a watchdog reset, clock running free
    @(posedge clk);
    {if_sel, tw_sdi, run, wdog} <= 4'hf;
    @(posedge clk);
    wdog <= 1'b0;
    repeat (3) @(negedge clk);
    chk({tw, osr_hi}, 32'h3);
    next_fall(2000, n);
    chk(32'(n), 32'h7d0);
    // Ratio 512 from the pin: next frame carries 0x200, one bit high for two cycles
    n = 0;
    while (result !== 24'h200 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk(32'(result), 32'h200);
    ones = 0;
    repeat (60) begin
      @(negedge clk);
      if (sdo === 1'b1)
        ones++;
    end
    chk(32'(ones), 32'h2);
    @(posedge clk);
    {if_sel, run, wdog} <= 3'h1;
    @(posedge clk);
    wdog <= 1'b0;
    repeat (3) @(negedge clk);
    chk({31'h0, tw}, 32'h0);
    report_and_stop();
  end

  // Hang guard, well beyond the expected run of some 45000 cycles
  initial begin
    repeat (70000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
